// *** rtl/asw_antenna_switch.sv ***
`timescale 1ns/1ps
module asw_antenna_switch import asw_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic seq_start,
  input wire logic [3:0] descriptor_tx_select,
  input wire logic desc_rts_en,
  input wire logic desc_directed,
  input wire logic key_last_ant,
  input wire logic ack_send,
  input wire logic tx_end,
  input wire logic resp_ok,
  input wire logic resp_fail,
  input wire logic [7:0] rssi,
  input wire logic div_valid,
  input wire logic [3:0] div_ant,
  output logic key_ant_wr,
  output logic key_ant_new,
  output logic [3:0] chosen_ant,
  output logic lna_ctrl,
  output logic switch_out_d,
  output logic switch_out_c,
  output logic switch_out_b,
  output logic switch_out_a
);
  asw_sel_if sel ();

  logic [31:0] idle_switch_config;
  logic [31:0] switch_entries_first;
  logic [31:0] switch_entries_second;
  logic [3:0] listen_select_field;
  logic prefer_default_flag;
  logic track_last_tx_flag;
  logic rts_on_default_flag;
  logic [7:0] att1_thr;
  logic [7:0] att2_thr;
  asw_state_t state;
  asw_state_t next_state;
  logic [3:0] data_ant;
  logic [3:0] next_data_ant;
  logic auto_mode;
  logic fail_odd;
  logic [ENTRY_W-1:0] entry;
  logic [3:0] mac_ant;
  logic wr_listen_sw;
  logic track_hit;
  logic fail_event;
  logic desc_dir_q;

  // Write strobe aimed at one register
  function automatic logic wr_hit(input logic [15:0] ofs);
    wr_hit = reg_wr && (reg_addr == ofs);
  endfunction

  // Idle control word; bits beyond the named fields are plain storage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_switch_config <= RST_IDLE_CFG;
    end else if (wr_hit(OFS_IDLE_CFG)) begin
      idle_switch_config <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      switch_entries_first <= RST_TABLE;
    end else if (wr_hit(OFS_TABLE1)) begin
      switch_entries_first <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      switch_entries_second <= RST_TABLE;
    end else if (wr_hit(OFS_TABLE2)) begin
      switch_entries_second <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prefer_default_flag <= 1'b0;
      track_last_tx_flag <= 1'b0;
      rts_on_default_flag <= 1'b0;
    end else if (wr_hit(OFS_STA_ID)) begin
      prefer_default_flag <= reg_wdata[STA_PREFER_BIT];
      track_last_tx_flag <= reg_wdata[STA_TRACK_BIT];
      rts_on_default_flag <= reg_wdata[STA_RTS_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      att1_thr <= RST_ATT1;
      att2_thr <= RST_ATT2;
    end else if (wr_hit(OFS_ATTEN)) begin
      att1_thr <= reg_wdata[7:0];
      att2_thr <= reg_wdata[15:8];
    end
  end

  // Default antenna field: software writes it, tracking hardware too
  assign wr_listen_sw = reg_wr && (reg_addr == OFS_LISTEN);
  assign track_hit = (state == ST_TX_DATA) && tx_end && auto_mode && track_last_tx_flag;

  // Hardware update wins over a software write in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      listen_select_field <= RST_LISTEN;
    end else if (track_hit) begin
      listen_select_field <= data_ant;
    end else if (wr_listen_sw) begin
      listen_select_field <= reg_wdata[3:0];
    end
  end

  // Read port: data stand one cycle after the strobe only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_IDLE_CFG: reg_rdata <= idle_switch_config;
        OFS_TABLE1: reg_rdata <= switch_entries_first;
        OFS_TABLE2: reg_rdata <= switch_entries_second;
        OFS_LISTEN: reg_rdata <= {28'h0, listen_select_field};
        OFS_STA_ID: begin
          reg_rdata <= {29'h0, rts_on_default_flag, track_last_tx_flag,
                        prefer_default_flag};
        end
        OFS_ATTEN: reg_rdata <= {16'h0, att2_thr, att1_thr};
        OFS_STATUS: begin
          reg_rdata <= {10'h0, entry, fail_odd, data_ant, chosen_ant, state};
        end
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Transmit antenna chosen when a frame sequence starts
  always_comb begin
    next_data_ant = data_ant;
    if (descriptor_tx_select == ANT_INVERT) begin
      next_data_ant = ant_flip(data_ant);
    end else if (descriptor_tx_select != 4'h0) begin
      next_data_ant = descriptor_tx_select;
    end else if (prefer_default_flag) begin
      next_data_ant = listen_select_field[0] ? ANT_ONE : ANT_TWO;
    end else begin
      next_data_ant = key_last_ant ? ANT_TWO : ANT_ONE;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_ant <= ANT_ONE;
    end else if ((state == ST_LISTEN) && seq_start && !ack_send) begin
      data_ant <= next_data_ant;
    end else if (fail_event && fail_odd && auto_mode && !prefer_default_flag) begin
      data_ant <= ant_flip(data_ant);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      auto_mode <= 1'b0;
    end else if ((state == ST_LISTEN) && seq_start && !ack_send) begin
      auto_mode <= (descriptor_tx_select == 4'h0);
    end
  end

  // Sequence state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (idle_switch_config[IDLE_RUN_BIT]) begin
          next_state = ST_LISTEN;
        end
      end
      ST_LISTEN: begin
        if (!idle_switch_config[IDLE_RUN_BIT]) begin
          next_state = ST_IDLE;
        end else if (ack_send) begin
          next_state = ST_TX_ACK;
        end else if (seq_start) begin
          next_state = desc_rts_en ? ST_TX_RTS : ST_TX_DATA;
        end
      end
      ST_TX_RTS: begin
        if (tx_end) begin
          next_state = ST_WAIT_CTS;
        end
      end
      ST_WAIT_CTS: begin
        if (resp_ok) begin
          next_state = ST_TX_DATA;
        end else if (resp_fail) begin
          next_state = ST_LISTEN;
        end
      end
      ST_TX_DATA: begin
        if (tx_end) begin
          next_state = desc_dir_q ? ST_WAIT_ACK : ST_LISTEN;
        end
      end
      ST_WAIT_ACK: begin
        if (resp_ok || resp_fail) begin
          next_state = ST_LISTEN;
        end
      end
      ST_TX_ACK: begin
        if (tx_end) begin
          next_state = ST_LISTEN;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Directed flag held for the whole exchange
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      desc_dir_q <= 1'b0;
    end else if ((state == ST_LISTEN) && seq_start && !ack_send) begin
      desc_dir_q <= desc_directed;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Failure parity: every second failure moves the key antenna, for code zero with prefer off
  assign fail_event = resp_fail && ((state == ST_WAIT_ACK) || (state == ST_WAIT_CTS));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fail_odd <= 1'b0;
    end else if (fail_event) begin
      fail_odd <= ~fail_odd;
    end else if (resp_ok && (state == ST_WAIT_ACK)) begin
      fail_odd <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_ant_wr <= 1'b0;
    end else begin
      key_ant_wr <= fail_event && fail_odd && auto_mode && !prefer_default_flag;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_ant_new <= 1'b0;
    end else begin
      key_ant_new <= ant_second(ant_flip(data_ant));
    end
  end

  // Antenna the MAC wants for the present state
  always_comb begin
    mac_ant = listen_select_field;
    unique case (state)
      ST_IDLE: mac_ant = listen_select_field;
      ST_LISTEN: mac_ant = listen_select_field;
      ST_TX_RTS: begin
        mac_ant = rts_on_default_flag ? listen_select_field : data_ant;
      end
      ST_WAIT_CTS: mac_ant = data_ant;
      ST_TX_DATA: mac_ant = data_ant;
      ST_WAIT_ACK: mac_ant = data_ant;
      ST_TX_ACK: mac_ant = listen_select_field;
      default: mac_ant = listen_select_field;
    endcase
  end

  // Diversity override only in the listen state, after a detect
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chosen_ant <= ANT_ONE;
    end else if (idle_switch_config[IDLE_DIV_BIT] && div_valid &&
                 (state == ST_LISTEN)) begin
      chosen_ant <= div_ant;
    end else begin
      chosen_ant <= mac_ant;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel.ant_second <= 1'b0;
    end else begin
      sel.ant_second <= ant_second(chosen_ant);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel.xstate <= XS_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: sel.xstate <= XS_IDLE;
        ST_TX_RTS, ST_TX_DATA, ST_TX_ACK: sel.xstate <= XS_TX;
        default: sel.xstate <= XS_RX;
      endcase
    end
  end

  asw_atten_detect u_att (
    .clock(clock),
    .rst_n(rst_n),
    .band_24g(idle_switch_config[IDLE_BAND_BIT]),
    .rssi(rssi),
    .thr1(att1_thr),
    .thr2(att2_thr),
    .sel(sel.att)
  );

  asw_switch_table u_tbl (
    .clock(clock),
    .rst_n(rst_n),
    .idle_entry(idle_switch_config[IDLE_ENTRY_LSB +: ENTRY_W]),
    .table1(switch_entries_first),
    .table2(switch_entries_second),
    .sel(sel.table_side),
    .entry(entry)
  );

  // Entry bits 5 and 3..0 go straight to the pins; bit 4 is unused
  assign lna_ctrl = entry[5];
  assign switch_out_d = entry[3];
  assign switch_out_c = entry[2];
  assign switch_out_b = entry[1];
  assign switch_out_a = entry[0];
endmodule

// *** rtl/asw_pkg.sv ***
// What this block does
// - Listen on antenna from default field
// - Code zero: key cache or default LSB
// - Track flag rewrites default after transmit
// - RTS on descriptor or default antenna
// - Prefer and track controls act only for code zero; RTS on default acts for any code
// - Listen and send ACK on default
// - Await ACK on the data antenna
// - Receive CTS on the data antenna
// - AP toggles key antenna every second failure
// - STA tracks default; mode II uses key
// - Sectored data on descriptor sector antenna
// - Eleven six-bit entries, selected by state
// - Antenna 1 entries in first table register
// - Antenna 2 entries in second register
// - Entry drives LNA and switches D..A
// - 2.4 GHz: two attenuation steps by strength
// - Fast diversity overrides antenna after detect
// - Reset enters idle with zero entry
package asw_pkg;
  localparam logic [15:0] OFS_IDLE_CFG = 16'h9910;
  localparam logic [15:0] OFS_TABLE1 = 16'h9960;
  localparam logic [15:0] OFS_TABLE2 = 16'h9964;
  localparam logic [15:0] OFS_LISTEN = 16'h9970;
  localparam logic [15:0] OFS_STA_ID = 16'h9974;
  localparam logic [15:0] OFS_ATTEN = 16'h9978;
  localparam logic [15:0] OFS_STATUS = 16'h997c;
  // Idle control register fields
  localparam int IDLE_RUN_BIT = 0;
  localparam int IDLE_DIV_BIT = 1;
  localparam int IDLE_BAND_BIT = 2;
  localparam int IDLE_ENTRY_LSB = 4;
  localparam int ENTRY_W = 6;
  // Station id fields
  localparam int STA_PREFER_BIT = 0;
  localparam int STA_TRACK_BIT = 1;
  localparam int STA_RTS_BIT = 2;
  // Table register fields
  localparam int TBL_TX_LSB = 0;
  localparam int TBL_RX_LSB = 6;
  localparam int TBL_A1_LSB = 12;
  localparam int TBL_A2_LSB = 18;
  localparam int TBL_A12_LSB = 24;
  localparam logic [31:0] RST_IDLE_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_TABLE = 32'h0000_0000;
  localparam logic [3:0] RST_LISTEN = 4'h1;
  localparam logic [7:0] RST_ATT1 = 8'h80;
  localparam logic [7:0] RST_ATT2 = 8'hc0;
  localparam logic [3:0] ANT_ONE = 4'h1;
  localparam logic [3:0] ANT_TWO = 4'h2;
  localparam logic [3:0] ANT_INVERT = 4'hf;
  typedef enum logic [1:0] {
    XS_IDLE = 2'h0,
    XS_RX = 2'h1,
    XS_TX = 2'h2
  } asw_xstate_t;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_LISTEN = 7'h02,
    ST_TX_RTS = 7'h04,
    ST_WAIT_CTS = 7'h08,
    ST_TX_DATA = 7'h10,
    ST_WAIT_ACK = 7'h20,
    ST_TX_ACK = 7'h40
  } asw_state_t;
  // Antenna codes with odd LSB use the first table, even the second
  function automatic logic ant_second(input logic [3:0] code);
    ant_second = ~code[0];
  endfunction
  function automatic logic [3:0] ant_flip(input logic [3:0] code);
    ant_flip = ant_second(code) ? ANT_ONE : ANT_TWO;
  endfunction
endpackage

// *** rtl/asw_sel_if.sv ***
`timescale 1ns/1ps
interface asw_sel_if;
  import asw_pkg::*;
  logic ant_second;
  asw_xstate_t xstate;
  logic att1;
  logic att2;
  modport ctrl (output ant_second, output xstate);
  modport att (output att1, output att2);
  modport table_side (input ant_second, input xstate, input att1, input att2);
endinterface

// *** rtl/asw_atten_detect.sv ***
`timescale 1ns/1ps
module asw_atten_detect import asw_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic band_24g,
  input wire logic [7:0] rssi,
  input wire logic [7:0] thr1,
  input wire logic [7:0] thr2,
  asw_sel_if.att sel
);
  // Attenuation only exists in the 2.4 GHz band
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel.att1 <= 1'b0;
      sel.att2 <= 1'b0;
    end else begin
      sel.att1 <= band_24g && (rssi >= thr1);
      // Second step never without the first: its entry is unused
      sel.att2 <= band_24g && (rssi >= thr1) && (rssi >= thr2);
    end
  end
endmodule

// *** rtl/asw_switch_table.sv ***
`timescale 1ns/1ps
module asw_switch_table import asw_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ENTRY_W-1:0] idle_entry,
  input wire logic [31:0] table1,
  input wire logic [31:0] table2,
  asw_sel_if.table_side sel,
  output logic [ENTRY_W-1:0] entry
);
  logic [31:0] tbl;
  logic [ENTRY_W-1:0] next_entry;
  always_comb begin
    tbl = sel.ant_second ? table2 : table1;
    next_entry = idle_entry;
    unique case (sel.xstate)
      XS_IDLE: next_entry = idle_entry;
      XS_TX: next_entry = tbl[TBL_TX_LSB +: ENTRY_W];
      XS_RX: begin
        unique case ({sel.att2, sel.att1})
          2'b00: next_entry = tbl[TBL_RX_LSB +: ENTRY_W];
          2'b01: next_entry = tbl[TBL_A1_LSB +: ENTRY_W];
          2'b10: next_entry = tbl[TBL_A2_LSB +: ENTRY_W];
          2'b11: next_entry = tbl[TBL_A12_LSB +: ENTRY_W];
        endcase
      end
      default: next_entry = idle_entry;
    endcase
  end
  // Registered so a selector change never glitches the switches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      entry <= '0;
    end else begin
      entry <= next_entry;
    end
  end
endmodule

// *** bench/asw_rf_front.sv ***
`timescale 1ns/1ps
module asw_rf_front (
  input wire logic lna_ctrl,
  input wire logic switch_out_d,
  input wire logic switch_out_c,
  input wire logic switch_out_b,
  input wire logic switch_out_a,
  output logic [4:0] rf_path
);
  // Switches follow the pins with no decode, so a wrong bit shows as-is
  assign rf_path = {lna_ctrl, switch_out_d, switch_out_c, switch_out_b, switch_out_a};
endmodule

// *** bench/asw_antenna_switch_chk.sv ***
`timescale 1ns/1ps
module asw_antenna_switch_chk import asw_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic seq_start,
  input wire logic ack_send,
  input wire logic tx_end,
  input wire logic resp_ok,
  input wire logic resp_fail,
  input wire logic [7:0] rssi,
  input wire logic div_valid,
  input wire logic key_ant_wr,
  input wire logic [3:0] chosen_ant,
  input wire logic lna_ctrl,
  input wire logic switch_out_d,
  input wire logic switch_out_c,
  input wire logic switch_out_b,
  input wire logic switch_out_a
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [7:0] rssi_q;
  logic div_q;
  logic [2:0] quiet;
  logic busy;
  logic [4:0] pins;
  assign pins = {lna_ctrl, switch_out_d, switch_out_c, switch_out_b, switch_out_a};
  assign busy = reg_wr | reg_rd | seq_start | ack_send | tx_end | resp_ok | resp_fail
    | div_valid | div_q | (rssi != rssi_q);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rssi_q <= 8'h0;
      div_q <= 1'h0;
    end else begin
      rssi_q <= rssi;
      div_q <= div_valid;
    end
  end
  // Counts quiet edges; pins may only move a few cycles after a cause
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= 3'h0;
    end else if (busy) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  property p_rdata_quiet;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data outside its slot");
  property p_idle_rb;
    reg_wr && reg_addr == OFS_IDLE_CFG ##1 reg_rd && reg_addr == OFS_IDLE_CFG
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_idle_rb: assert property (p_idle_rb)
    else $error("idle config read back differs");
  property p_tbl1_rb;
    reg_wr && reg_addr == OFS_TABLE1 ##1 reg_rd && reg_addr == OFS_TABLE1
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_tbl1_rb: assert property (p_tbl1_rb)
    else $error("first table read back differs");
  property p_tbl2_rb;
    reg_wr && reg_addr == OFS_TABLE2 ##1 reg_rd && reg_addr == OFS_TABLE2
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_tbl2_rb: assert property (p_tbl2_rb)
    else $error("second table read back differs");
  property p_reset_pins;
    $rose(rst_n) |-> pins == 5'h0;
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("pins not zero after reset");
  property p_reset_ant;
    $rose(rst_n) |-> chosen_ant == 4'h1;
  endproperty
  a_reset_ant: assert property (p_reset_ant)
    else $error("antenna not one after reset");
  property p_key_pulse;
    key_ant_wr |=> !key_ant_wr;
  endproperty
  a_key_pulse: assert property (p_key_pulse)
    else $error("key write longer than one cycle");
  property p_key_cause;
    key_ant_wr |-> $past(resp_fail) || $past(resp_fail, 2);
  endproperty
  a_key_cause: assert property (p_key_cause)
    else $error("key write without a failure");
  property p_quiet_stable;
    quiet >= 3'h6 |-> $stable(pins) && $stable(chosen_ant);
  endproperty
  a_quiet_stable: assert property (p_quiet_stable)
    else $error("pins moved without a cause");
endmodule
bind asw_antenna_switch asw_antenna_switch_chk chk_u (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .seq_start(seq_start), .ack_send(ack_send), .tx_end(tx_end),
  .resp_ok(resp_ok), .resp_fail(resp_fail), .rssi(rssi), .div_valid(div_valid),
  .key_ant_wr(key_ant_wr), .chosen_ant(chosen_ant), .lna_ctrl(lna_ctrl),
  .switch_out_d(switch_out_d), .switch_out_c(switch_out_c), .switch_out_b(switch_out_b),
  .switch_out_a(switch_out_a));

// *** bench/test_asw_antenna_switch.sv ***
`timescale 1ns/1ps
module test_asw_antenna_switch import asw_pkg::*;;
  localparam logic [31:0] TB1 = {2'h0, 6'h2c, 6'h08, 6'h24, 6'h02, 6'h21};
  localparam logic [31:0] TB2 = {2'h0, 6'h2f, 6'h0a, 6'h26, 6'h05, 6'h23};
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [4:0] evt = 5'h0;
  logic [3:0] code = 4'h0;
  logic rts = 1'h0;
  logic dir = 1'h0;
  logic key = 1'h0;
  logic [7:0] rssi = 8'h0;
  logic dv = 1'h0;
  logic [3:0] dant = 4'h0;
  logic [31:0] rdata;
  logic kwr, knew, lna, sd, sc, sb, sa;
  logic [3:0] ant;
  logic [4:0] path;
  logic [31:0] v;
  int miscompares = 0;
  int n_checks = 0;
  asw_antenna_switch dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .seq_start(evt[4]),
    .descriptor_tx_select(code), .desc_rts_en(rts), .desc_directed(dir),
    .key_last_ant(key), .ack_send(evt[3]), .tx_end(evt[2]), .resp_ok(evt[1]),
    .resp_fail(evt[0]), .rssi(rssi), .div_valid(dv), .div_ant(dant), .key_ant_wr(kwr),
    .key_ant_new(knew), .chosen_ant(ant), .lna_ctrl(lna), .switch_out_d(sd),
    .switch_out_c(sc), .switch_out_b(sb), .switch_out_a(sa));
  asw_rf_front rf_u (.lna_ctrl(lna), .switch_out_d(sd), .switch_out_c(sc),
    .switch_out_b(sb), .switch_out_a(sa), .rf_path(path));
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask
  task automatic rreg(input logic [15:0] a);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    @(posedge clock);
    v = rdata;
  endtask
  task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] e);
    rreg(a);
    ck(n, e, v);
  endtask
  // Pins settle three cycles after a cause; six leaves margin for writes
  task automatic pins(input logic [5:0] e, input logic [3:0] a);
    repeat (6) @(posedge clock);
    ck("pins", 32'({e[5], e[3:0]}), 32'(path));
    ck("chosen_ant", 32'(a), 32'(ant));
  endtask
  task automatic st(input int i, input logic [5:0] e, input logic [3:0] a);
    evt[i] <= 1'h1;
    @(posedge clock);
    evt <= 5'h0;
    pins(e, a);
  endtask
  task automatic go(input logic [3:0] c, input logic [2:0] f, input logic [5:0] e,
    input logic [3:0] a);
    code <= c;
    {rts, dir, key} <= f;
    st(4, e, a);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    ck("reset pins", 32'h0, 32'(path));
    ck("reset ant", 32'h1, 32'(ant));
    rchk("idle cfg", OFS_IDLE_CFG, 32'h0);
    $display("test reset done");
    wreg(OFS_TABLE1, TB1);
    rchk("table1", OFS_TABLE1, TB1);
    wreg(OFS_TABLE2, TB2);
    rchk("table2", OFS_TABLE2, TB2);
    wreg(OFS_IDLE_CFG, 32'h8000_0250);
    rchk("idle cfg", OFS_IDLE_CFG, 32'h8000_0250);
    pins(6'h25, 4'h1);
    rreg(OFS_IDLE_CFG);
    wreg(OFS_IDLE_CFG, v | 32'h1);
    pins(TB1[11:6], 4'h1);
    wreg(OFS_LISTEN, 32'h2);
    pins(TB2[11:6], 4'h2);
    $display("test table done");
    wreg(OFS_STA_ID, 32'h0);
    @(posedge clock);
    wreg(OFS_LISTEN, 32'h1);
    go(4'h0, 3'b011, TB2[5:0], 4'h2);
    st(2, TB2[11:6], 4'h2);
    st(1, TB1[11:6], 4'h1);
    wreg(OFS_STA_ID, 32'h2);
    go(4'h0, 3'b001, TB2[5:0], 4'h2);
    st(2, TB2[11:6], 4'h2);
    rchk("track on", OFS_LISTEN, 32'h2);
    wreg(OFS_STA_ID, 32'h0);
    go(4'h0, 3'b000, TB1[5:0], 4'h1);
    st(2, TB2[11:6], 4'h2);
    rchk("track off", OFS_LISTEN, 32'h2);
    $display("test omni done");
    wreg(OFS_STA_ID, 32'h7);
    @(posedge clock);
    wreg(OFS_LISTEN, 32'h1);
    go(4'h0, 3'b101, TB1[5:0], 4'h1);
    st(2, TB1[11:6], 4'h1);
    st(1, TB1[5:0], 4'h1);
    st(2, TB1[11:6], 4'h1);
    rchk("sta track", OFS_LISTEN, 32'h1);
    wreg(OFS_STA_ID, 32'h4);
    go(4'h4, 3'b110, TB1[5:0], 4'h1);
    st(2, TB2[11:6], 4'h4);
    st(1, TB2[5:0], 4'h4);
    st(2, TB2[11:6], 4'h4);
    st(1, TB1[11:6], 4'h1);
    wreg(OFS_STA_ID, 32'h0);
    go(4'h6, 3'b100, TB2[5:0], 4'h6);
    st(2, TB2[11:6], 4'h6);
    st(1, TB2[5:0], 4'h6);
    st(2, TB1[11:6], 4'h1);
    st(3, TB1[5:0], 4'h1);
    st(2, TB1[11:6], 4'h1);
    $display("test sector done");
    go(4'h0, 3'b110, TB1[5:0], 4'h1);
    st(2, TB1[11:6], 4'h1);
    st(0, TB1[11:6], 4'h1);
    go(4'h0, 3'b110, TB1[5:0], 4'h1);
    st(2, TB1[11:6], 4'h1);
    evt[0] <= 1'h1;
    @(posedge clock);
    evt <= 5'h0;
    for (int i = 0; i < 8 && kwr !== 1'h1; i++) begin
      @(posedge clock);
    end
    if (kwr !== 1'h1) begin
      miscompares++;
      $display("[FAIL] key_ant_wr expected 1 seen %b", kwr);
      results();
    end
    ck("key_ant_new", 32'h1, 32'(knew));
    // Invert code must start from the antenna the failure moved to
    go(4'hf, 3'b000, TB1[5:0], 4'h1);
    st(2, TB1[11:6], 4'h1);
    $display("test failure done");
    rreg(OFS_IDLE_CFG);
    wreg(OFS_IDLE_CFG, v | 32'h4);
    rchk("thresholds", OFS_ATTEN, {16'h0, RST_ATT2, RST_ATT1});
    rssi <= 8'h90;
    pins(TB1[17:12], 4'h1);
    rssi <= 8'hd0;
    pins(TB1[29:24], 4'h1);
    rssi <= 8'h00;
    pins(TB1[11:6], 4'h1);
    rreg(OFS_IDLE_CFG);
    wreg(OFS_IDLE_CFG, v | 32'h2);
    dant <= 4'h2;
    dv <= 1'h1;
    pins(TB2[11:6], 4'h2);
    dv <= 1'h0;
    pins(TB1[11:6], 4'h1);
    $display("test switch done");
    results();
  end
endmodule
